// [hdl/spi_cmd_pkg.sv]
/*
  shared constants and types for the serial command checker.
  assumes a single 16-bit frame format, address in the low byte.
*/
package spi_cmd_pkg;
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] FRAME_CNT = 5'h10;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONES = 16'hFFFF;
  // register addresses
  localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
  localparam logic [6:0] ADDR_HW_CTRL = 7'h02;
  localparam logic [6:0] ADDR_WATCHDOG_CONTROL_REG = 7'h03;
  localparam logic [6:0] ADDR_BUS_CTRL = 7'h04;
  localparam logic [6:0] ADDR_WAKE_CTRL = 7'h06;
  localparam logic [6:0] ADDR_TIMER_CTRL = 7'h0C;
  localparam logic [6:0] ADDR_DEV_STAT = 7'h43;
  localparam int STATUS_SPACE_BIT = 6;
  // mode control field
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;
  localparam logic [1:0] REQ_NORMAL = 2'h0;
  localparam logic [1:0] REQ_SLEEP = 2'h1;
  localparam logic [1:0] REQ_STOP = 2'h2;
  localparam logic [1:0] REQ_SOFT_RESET = 2'h3;
  // hardware control field
  localparam int LOAD_SHARE_BIT = 0;
  // wake control fields
  localparam int WAKE_IN1_BIT = 0;
  localparam int WAKE_IN2_BIT = 1;
  localparam int WAKE_IN3_BIT = 2;
  localparam int WAKE_TIMER_BIT = 3;
  localparam int WAKE_MEAS_BIT = 5;
  localparam logic [7:0] WAKE_SRC_MASK = 8'h0F;
  // timer control fields
  localparam int TMR_PER_MSB = 3;
  localparam int TMR_PER_LSB = 0;
  localparam int TMR_ON_MSB = 7;
  localparam int TMR_ON_LSB = 4;
  localparam logic [3:0] TMR_OFF = 4'h0;
  // device status clear bit for the failure flag
  localparam int FAIL_CLR_BIT = 0;
  // reset values
  localparam logic [15:0] RX_RST = 16'h0000;
  localparam logic [15:0] TX_RST = 16'h0000;

  typedef enum logic [2:0] {
    MODE_INIT = 3'b000,
    MODE_NORMAL = 3'b001,
    MODE_STOP = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_RESTART = 3'b100,
    MODE_SOFT_RESET = 3'b101
  } sbc_mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic wr;
    logic [6:0] addr;
  } cmd_t;
endpackage

// [hdl/spi_cmd_checker.sv]
/*
  serial slave front end with command checking and frame error flag.
  assumes the register file and mode state machine sit outside on ref_clk,
  and that the master keeps the serial clock low while chip select is high.
*/
// Contract
// RL1 - 16-bit word in, 16-bit word out per frame
// RL2 - frame opens low, word used after release
// RL3 - output released when chip select returns high
// RL4 - input sampled on falling serial clock
// RL5 - output advances after rising clock, no pass-through
// RL6 - invalid write ignored, sticky fail until cleared
// RL7 - stop to sleep fails, go restart
// RL8 - stop/sleep from init fails, go normal
// RL9 - watchdog byte odd parity fails, discarded
// RL10 - stop mode allows four command kinds only
// RL11 - stop with wake status pending pulses interrupt
// RL12 - stop to normal changes only mode bits
// RL13 - sleep without wake sources fails, restart, rest executes
// RL14 - lone timer wake while timer off restarts; code restarts on any lone timer wake, timer state not checked
// RL15 - stop without wake sources is accepted
// RL16 - load sharing bit cannot be cleared
// RL17 - sleep with level measure, only inputs one/two fails
// RL18 - timer on-time not below period fails
// RL19 - all-zero or all-one word fails
// RL20 - bad clock count or clock high flags error
// RL21 - frame overlapping reset low flags error, output high
// RL22 - master keeps clock low at select edges
// RL23 - bits 6..0 address, bit 7 write, 15..8 data
// RL24 - no command interpreted during restart
`timescale 1ns/1ps
module spi_cmd_checker import spi_cmd_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic spi_clk,
  input wire logic chip_select_low,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic reset_output_pin,
  input wire sbc_mode_t cur_mode,
  input wire logic [7:0] mode_ctrl_reg,
  input wire logic [7:0] hw_ctrl_reg,
  input wire logic [7:0] bus_ctrl_reg,
  input wire logic [7:0] wake_control_reg,
  input wire logic [7:0] wake_status_reg_a,
  input wire logic [7:0] wake_status_reg_b,
  input wire logic [7:0] read_data,
  input wire logic [6:0] status_field,
  output cmd_t cmd_ff,
  output logic cmd_valid_ff,
  output sbc_mode_t mode_req_ff,
  output logic mode_req_valid_ff,
  output logic wake_int_ff,
  output logic spi_fail_ff,
  output logic frame_err_ff
);
  logic link_rst_ff;
  logic neg_armed_ff;
  logic pos_armed_ff;
  logic [4:0] neg_cnt_ff;
  logic [4:0] pos_cnt_ff;
  logic neg_tgl_ff;
  logic pos_tgl_ff;
  logic [15:0] rx_ff;
  logic oe_ff;
  logic [1:0] csn_sync_ff;
  logic [1:0] clk_sync_ff;
  logic [1:0] neg_tgl_sync_ff;
  logic [1:0] pos_tgl_sync_ff;
  logic csn_prev_ff;
  logic neg_seen_ff;
  logic pos_seen_ff;
  logic clk_high_edge_ff;
  logic ro_low_frame_ff;
  logic ro_low_ff;
  logic [15:0] tx_ff;
  logic frame_start;
  logic frame_end;
  logic [4:0] neg_frame;
  logic [4:0] pos_frame;
  logic frame_bad;
  logic [3:0] tx_idx;

  // link side reset, taken from the system side
  always_ff @(posedge ref_clk) begin
    link_rst_ff <= rst;
  end

  // output enable follows chip select on both edges
  always_ff @(negedge chip_select_low or posedge chip_select_low or posedge link_rst_ff) begin
    if (chip_select_low || link_rst_ff) begin
      oe_ff <= 1'b0; // RL3
    end else begin
      oe_ff <= 1'b1; // RL2
    end
  end

  assign sdo_oe = oe_ff;

  // first falling edge of a frame is marked while chip select is high
  always_ff @(negedge spi_clk or posedge chip_select_low or posedge link_rst_ff) begin
    if (chip_select_low || link_rst_ff) begin
      neg_armed_ff <= 1'b1;
    end else begin
      neg_armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge spi_clk or posedge chip_select_low or posedge link_rst_ff) begin
    if (chip_select_low || link_rst_ff) begin
      pos_armed_ff <= 1'b1;
    end else begin
      pos_armed_ff <= 1'b0;
    end
  end

  // input shift and falling edge count
  always_ff @(negedge spi_clk or posedge link_rst_ff) begin
    if (link_rst_ff) begin
      rx_ff <= RX_RST;
      neg_cnt_ff <= 5'h00;
      neg_tgl_ff <= 1'b0;
    end else begin
      rx_ff <= {sdi, rx_ff[15:1]}; // RL4
      if (neg_armed_ff) begin
        neg_cnt_ff <= 5'h01;
        neg_tgl_ff <= ~neg_tgl_ff;
      end else if (neg_cnt_ff != CNT_MAX) begin
        neg_cnt_ff <= neg_cnt_ff + 5'h01; // RL20
      end
    end
  end

  // rising edge count, selects the next output bit
  always_ff @(posedge spi_clk or posedge link_rst_ff) begin
    if (link_rst_ff) begin
      pos_cnt_ff <= 5'h00;
      pos_tgl_ff <= 1'b0;
    end else if (pos_armed_ff) begin
      pos_cnt_ff <= 5'h01;
      pos_tgl_ff <= ~pos_tgl_ff;
    end else if (pos_cnt_ff != CNT_MAX) begin
      pos_cnt_ff <= pos_cnt_ff + 5'h01;
    end
  end

  assign tx_idx = pos_armed_ff ? 4'h0 : pos_cnt_ff[3:0];
  // response bit from the held word, no pass-through of input bits
  assign sdo = ro_low_ff | tx_ff[tx_idx]; // RL5 RL21

  // crossings into the system clock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      csn_sync_ff <= 2'h3;
      clk_sync_ff <= 2'h0;
      neg_tgl_sync_ff <= 2'h0;
      pos_tgl_sync_ff <= 2'h0;
    end else begin
      csn_sync_ff <= {csn_sync_ff[0], chip_select_low};
      clk_sync_ff <= {clk_sync_ff[0], spi_clk};
      neg_tgl_sync_ff <= {neg_tgl_sync_ff[0], neg_tgl_ff};
      pos_tgl_sync_ff <= {pos_tgl_sync_ff[0], pos_tgl_ff};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      csn_prev_ff <= 1'b1;
    end else begin
      csn_prev_ff <= csn_sync_ff[1];
    end
  end

  assign frame_start = csn_prev_ff & ~csn_sync_ff[1];
  assign frame_end = ~csn_prev_ff & csn_sync_ff[1]; // RL2
  assign neg_frame = (neg_tgl_sync_ff[1] != neg_seen_ff) ? neg_cnt_ff : 5'h00;
  assign pos_frame = (pos_tgl_sync_ff[1] != pos_seen_ff) ? pos_cnt_ff : 5'h00;
  assign frame_bad = ((neg_frame != 5'h00) && (neg_frame != FRAME_CNT)) ||
                     (neg_frame != pos_frame) || clk_high_edge_ff || clk_sync_ff[1]; // RL20 RL22

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      neg_seen_ff <= 1'b0;
      pos_seen_ff <= 1'b0;
    end else if (frame_end) begin
      neg_seen_ff <= neg_tgl_sync_ff[1];
      pos_seen_ff <= pos_tgl_sync_ff[1];
    end
  end

  // clock seen high at the opening edge of chip select
  always_ff @(posedge ref_clk) begin
    if (rst || frame_end) begin
      clk_high_edge_ff <= 1'b0;
    end else if (frame_start && clk_sync_ff[1]) begin
      clk_high_edge_ff <= 1'b1; // RL20
    end
  end

  // reset output low at any time during a frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ro_low_ff <= 1'b0;
    end else begin
      ro_low_ff <= ~reset_output_pin;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || frame_start) begin
      ro_low_frame_ff <= ~reset_output_pin & frame_start;
    end else if (~csn_sync_ff[1] || frame_end) begin
      if (~reset_output_pin) begin
        ro_low_frame_ff <= 1'b1; // RL21
      end
    end
  end

  // error flag kept until reported in a clean frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame_err_ff <= 1'b0;
    end else if (frame_end) begin
      frame_err_ff <= frame_bad | ro_low_frame_ff | ~reset_output_pin; // RL20 RL21
    end
  end

  // response word held steady during a frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_ff <= TX_RST;
    end else if (csn_sync_ff[1] && csn_prev_ff) begin
      tx_ff <= {read_data, status_field, frame_err_ff}; // RL1 RL20
    end
  end

  // command checking
  cmd_t rx_cmd;
  logic [1:0] req;
  logic is_write;
  logic is_status;
  logic wake_none;
  logic fail;
  logic take;
  logic mode_go;
  sbc_mode_t mode_next;
  logic [7:0] data_out;
  logic int_go;

  assign rx_cmd = rx_ff; // RL23
  assign req = rx_cmd.data[MODE_MSB:MODE_LSB];
  assign is_status = rx_cmd.addr[STATUS_SPACE_BIT];
  assign is_write = rx_cmd.wr;
  assign wake_none = (bus_ctrl_reg == 8'h00) && ((wake_control_reg & WAKE_SRC_MASK) == 8'h00);

  always_comb begin
    fail = 1'b0;
    take = 1'b1;
    mode_go = 1'b0;
    mode_next = cur_mode;
    data_out = rx_cmd.data;
    int_go = 1'b0;
    if ((rx_ff == WORD_ZERO) || (rx_ff == WORD_ONES)) begin
      fail = 1'b1; // RL19
      take = 1'b0;
    end else if (is_write && !is_status) begin
      if (cur_mode == MODE_STOP && rx_cmd.addr != ADDR_MODE_CTRL && rx_cmd.addr != ADDR_WATCHDOG_CONTROL_REG) begin
        fail = 1'b1; // RL10
        take = 1'b0;
      end else begin
        unique case (rx_cmd.addr)
          ADDR_MODE_CTRL: begin
            mode_go = 1'b1;
            unique case (req)
              REQ_NORMAL: begin
                mode_next = MODE_NORMAL;
                if (cur_mode == MODE_STOP) begin
                  data_out = {REQ_NORMAL, mode_ctrl_reg[MODE_LSB-1:0]}; // RL12
                end
              end
              REQ_SOFT_RESET: mode_next = MODE_SOFT_RESET;
              REQ_STOP: begin
                if (cur_mode == MODE_INIT) begin
                  fail = 1'b1; // RL8
                  take = 1'b0;
                  mode_next = MODE_NORMAL;
                end else begin
                  mode_next = MODE_STOP; // RL15
                  int_go = (wake_status_reg_a != 8'h00) || (wake_status_reg_b != 8'h00); // RL11
                end
              end
              REQ_SLEEP: begin
                if (cur_mode == MODE_STOP) begin
                  fail = 1'b1; // RL7
                  take = 1'b0;
                  mode_next = MODE_RESTART;
                end else if (cur_mode == MODE_INIT) begin
                  fail = 1'b1; // RL8
                  take = 1'b0;
                  mode_next = MODE_NORMAL;
                end else if (wake_none) begin
                  fail = 1'b1; // RL13
                  mode_next = MODE_RESTART;
                end else if (wake_control_reg[WAKE_MEAS_BIT] && bus_ctrl_reg == 8'h00 &&
                             !wake_control_reg[WAKE_IN3_BIT] && !wake_control_reg[WAKE_TIMER_BIT]) begin
                  fail = 1'b1; // RL17
                  mode_next = MODE_RESTART;
                end else if (bus_ctrl_reg == 8'h00 && (wake_control_reg & WAKE_SRC_MASK) == 8'h08) begin
                  mode_next = MODE_RESTART; // RL14
                end else begin
                  mode_next = MODE_SLEEP;
                end
              end
            endcase
            if (cur_mode == MODE_STOP && mode_next != MODE_NORMAL && mode_next != MODE_SOFT_RESET
                && mode_next != MODE_RESTART) begin
              fail = 1'b1; // RL10
              take = 1'b0;
              mode_go = 1'b0;
              int_go = 1'b0; // RL11
            end
          end
          ADDR_WATCHDOG_CONTROL_REG: begin
            if (^rx_cmd.data) begin
              fail = 1'b1; // RL9
              take = 1'b0;
            end
          end
          ADDR_HW_CTRL: begin
            if (hw_ctrl_reg[LOAD_SHARE_BIT]) begin
              data_out[LOAD_SHARE_BIT] = 1'b1; // RL16
            end
          end
          ADDR_TIMER_CTRL: begin
            if (rx_cmd.data[TMR_ON_MSB:TMR_ON_LSB] >= rx_cmd.data[TMR_PER_MSB:TMR_PER_LSB]) begin
              fail = 1'b1; // RL18
              take = 1'b0;
            end
          end
          default: take = 1'b1;
        endcase
      end
    end
  end

  logic accept;
  assign accept = frame_end && !frame_bad && !ro_low_frame_ff && reset_output_pin && (neg_frame == FRAME_CNT) &&
                  cur_mode != MODE_RESTART; // RL20 RL21 RL24

  // write or clear strobe toward the register file
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_ff <= '0;
      cmd_valid_ff <= 1'b0;
    end else begin
      cmd_valid_ff <= accept && take; // RL6
      if (accept && take) begin
        cmd_ff <= '{data: data_out, wr: rx_cmd.wr, addr: rx_cmd.addr};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_req_ff <= MODE_INIT;
      mode_req_valid_ff <= 1'b0;
      wake_int_ff <= 1'b0;
    end else begin
      mode_req_valid_ff <= accept && mode_go; // RL7 RL8 RL13
      wake_int_ff <= accept && int_go; // RL11
      if (accept && mode_go) begin
        mode_req_ff <= mode_next;
      end
    end
  end

  // sticky failure flag, a new failure wins over the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      spi_fail_ff <= 1'b0;
    end else if (accept && fail) begin
      spi_fail_ff <= 1'b1; // RL6
    end else if (accept && is_write && rx_cmd.addr == ADDR_DEV_STAT && rx_cmd.data[FAIL_CLR_BIT]) begin
      spi_fail_ff <= 1'b0; // RL6
    end
  end
endmodule // spi_cmd_checker

// [bench/spi_cmd_checker_sva.sv]
/*
  concurrent checks on the command checker ports.
  assumes ref_clk domain flags and a master that idles between frames.
*/
`timescale 1ns/1ps
module spi_cmd_checker_sva import spi_cmd_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic chip_select_low,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic reset_output_pin,
  input wire sbc_mode_t cur_mode,
  input wire cmd_t cmd_ff,
  input wire logic cmd_valid_ff,
  input wire sbc_mode_t mode_req_ff,
  input wire logic mode_req_valid_ff,
  input wire logic wake_int_ff,
  input wire logic spi_fail_ff,
  input wire logic frame_err_ff
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  oe_release_a: assert property (chip_select_low [*3] |-> !sdo_oe)
    else $error("sdo driven with select high");
  oe_drive_a: assert property (!chip_select_low [*3] |-> sdo_oe)
    else $error("sdo not driven in frame");
  ro_high_a: assert property (!reset_output_pin && $past(!reset_output_pin) && sdo_oe |-> sdo)
    else $error("sdo low while reset output low");
  cmd_closed_a: assert property (cmd_valid_ff |-> $past(chip_select_low) && $past(chip_select_low, 2))
    else $error("command before select release");
  cmd_pulse_a: assert property (cmd_valid_ff |=> !cmd_valid_ff)
    else $error("command valid longer than one cycle");
  no_stuck_a: assert property (cmd_valid_ff |-> cmd_ff != WORD_ZERO && cmd_ff != WORD_ONES)
    else $error("stuck word accepted");
  restart_quiet_a: assert property (cmd_valid_ff || mode_req_valid_ff |-> $past(cur_mode) != MODE_RESTART)
    else $error("command used in restart");
  init_normal_a: assert property (mode_req_valid_ff && $past(cur_mode) == MODE_INIT
    |-> mode_req_ff != MODE_STOP && mode_req_ff != MODE_SLEEP)
    else $error("low power entered from init");
  stop_sleep_a: assert property (mode_req_valid_ff && $past(cur_mode) == MODE_STOP |-> mode_req_ff != MODE_SLEEP)
    else $error("sleep entered from stop");
  flags_closed_a: assert property ($changed(spi_fail_ff) || $changed(frame_err_ff) |-> $past(chip_select_low, 2))
    else $error("flag changed inside frame");
  wake_int_a: assert property (wake_int_ff |-> !$rose(spi_fail_ff))
    else $error("fail set with wake interrupt");
  cmd_seen_c: cover property (cmd_valid_ff);
  fail_seen_c: cover property ($rose(spi_fail_ff));
  err_seen_c: cover property ($rose(frame_err_ff));
endmodule // spi_cmd_checker_sva
bind spi_cmd_checker spi_cmd_checker_sva spi_cmd_checker_sva_inst (.*);

// [bench/spi_master_model.sv]
/*
  serial master model: select, 30 ns clock and data, bit0 first.
  assumes the caller spaces frames; clock stands low outside frames.
*/
`timescale 1ns/1ps
module spi_master_model (
  output logic spi_clk,
  output logic chip_select_low,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    spi_clk = 1'b0;
    chip_select_low = 1'b1;
    sdi = 1'b0;
  end
  task automatic frame(input logic [15:0] word, input int nclk, output logic [15:0] resp);
    resp = 16'h0000;
    chip_select_low = 1'b0;
    #400;
    for (int i = 0; i < nclk; i++) begin
      resp[i] = sdo;
      #15 spi_clk = 1'b1;
      sdi = word[i];
      #15 spi_clk = 1'b0;
    end
    if (nclk == 0) resp[0] = sdo;
    #15 chip_select_low = 1'b1;
    sdi = ~sdi;
    #500;
  endtask
endmodule // spi_master_model

// [bench/tb_top.sv]
/*
  self-checking bench for the command checker.
  assumes the master model above and 100 ns ref_clk.
*/
`timescale 1ns/1ps
module tb_top import spi_cmd_pkg::*; ;
  logic ref_clk, rst, reset_output_pin, spi_clk, chip_select_low, sdi, sdo, sdo_oe;
  logic cmd_valid_ff, mode_req_valid_ff, wake_int_ff, spi_fail_ff, frame_err_ff;
  sbc_mode_t cur_mode, mode_req_ff;
  logic [7:0] bus_ctrl_reg, wake_control_reg, wake_status_reg_a, read_data, cmd_seen, int_seen;
  logic [7:0] mode_ctrl_reg, hw_ctrl_reg, wake_status_reg_b;
  logic [6:0] status_field;
  logic [15:0] resp, last_cmd;
  cmd_t cmd_ff;
  int err_count = 0;
  int checks_done = 0;
  spi_master_model spi_master_model_inst (.spi_clk, .chip_select_low, .sdi, .sdo);
  spi_cmd_checker spi_cmd_checker_inst (.ref_clk, .rst, .spi_clk, .chip_select_low, .sdi, .sdo, .sdo_oe,
    .reset_output_pin, .cur_mode, .mode_ctrl_reg, .hw_ctrl_reg, .bus_ctrl_reg,
    .wake_control_reg, .wake_status_reg_a, .wake_status_reg_b, .read_data, .status_field,
    .cmd_ff, .cmd_valid_ff, .mode_req_ff, .mode_req_valid_ff, .wake_int_ff, .spi_fail_ff, .frame_err_ff);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cmd_seen <= rst ? 8'h00 : cmd_seen + cmd_valid_ff;
    int_seen <= rst ? 8'h00 : int_seen + wake_int_ff;
    if (cmd_valid_ff) last_cmd <= cmd_ff;
  end
  task automatic end_of_test;
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic send(input logic [15:0] w, input int n);
    spi_master_model_inst.frame(w, n, resp);
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic set_in(input sbc_mode_t m, input logic [7:0] bus, input logic [7:0] wk);
    cur_mode <= m;
    bus_ctrl_reg <= bus;
    wake_control_reg <= wk;
    @(posedge ref_clk);
  endtask
  task automatic cmd_case(input logic [15:0] w, input logic fail, input logic [7:0] ncmd, input sbc_mode_t req);
    logic [7:0] c0;
    c0 = cmd_seen;
    send(w, 16);
    chk("spi_fail", spi_fail_ff, fail);
    chk("cmd_count", cmd_seen - c0, ncmd);
    chk("mode_req", mode_req_ff, req);
    if (fail) begin
      send(16'h01C3, 16);
      chk("fail_clear", spi_fail_ff, 1'b0);
    end
  endtask
  task automatic s_write;
    cmd_case(16'h5A84, 1'b0, 8'h01, MODE_INIT);
    chk("cmd_word", last_cmd, 16'h5A84);
    send(16'h0004, 16);
    chk("response", resp, 16'hC32A);
  endtask
  task automatic s_modes;
    set_in(MODE_INIT, 8'h01, 8'h01);
    cmd_case(16'h8081, 1'b1, 8'h00, MODE_NORMAL);
    set_in(MODE_STOP, 8'h01, 8'h01);
    cmd_case(16'h4081, 1'b1, 8'h00, MODE_RESTART);
    cmd_case(16'h5A84, 1'b1, 8'h00, MODE_RESTART);
    set_in(MODE_RESTART, 8'h01, 8'h01);
    cmd_case(16'h5A84, 1'b0, 8'h00, MODE_RESTART);
    set_in(MODE_NORMAL, 8'h00, 8'h00);
    cmd_case(16'h4081, 1'b1, 8'h01, MODE_RESTART);
  endtask
  task automatic s_checks;
    cmd_case(16'h0183, 1'b1, 8'h00, MODE_RESTART);
    cmd_case(16'h338C, 1'b1, 8'h00, MODE_RESTART);
    cmd_case(16'h0000, 1'b1, 8'h00, MODE_RESTART);
    cmd_case(16'hFFFF, 1'b1, 8'h00, MODE_RESTART);
  endtask
  task automatic s_stop_wake;
    logic [7:0] c0;
    c0 = int_seen;
    cmd_case(16'h8081, 1'b0, 8'h01, MODE_STOP);
    set_in(MODE_NORMAL, 8'h01, 8'h01);
    wake_status_reg_a <= 8'h01;
    cmd_case(16'h8081, 1'b0, 8'h01, MODE_STOP);
    wake_status_reg_a <= 8'h00;
    wake_status_reg_b <= 8'h01;
    cmd_case(16'h8081, 1'b0, 8'h01, MODE_STOP);
    chk("wake_int", int_seen - c0, 8'h02);
    wake_status_reg_b <= 8'h00;
  endtask
  task automatic s_extra;
    mode_ctrl_reg <= 8'h15;
    set_in(MODE_STOP, 8'h01, 8'h01);
    cmd_case(16'hC081, 1'b0, 8'h01, MODE_SOFT_RESET);
    cmd_case(16'h0383, 1'b0, 8'h01, MODE_SOFT_RESET);
    cmd_case(16'h2A81, 1'b0, 8'h01, MODE_NORMAL);
    chk("cmd_word", last_cmd, 16'h1581);
    hw_ctrl_reg <= 8'h01;
    set_in(MODE_NORMAL, 8'h01, 8'h01);
    cmd_case(16'h3082, 1'b0, 8'h01, MODE_NORMAL);
    chk("cmd_word", last_cmd, 16'h3182);
    cmd_case(16'h4081, 1'b0, 8'h01, MODE_SLEEP);
    set_in(MODE_NORMAL, 8'h00, 8'h08);
    cmd_case(16'h4081, 1'b0, 8'h01, MODE_RESTART);
    set_in(MODE_NORMAL, 8'h00, 8'h21);
    cmd_case(16'h4081, 1'b1, 8'h01, MODE_RESTART);
  endtask
  task automatic s_frame;
    logic [7:0] c0;
    c0 = cmd_seen;
    send(16'h5A84, 8);
    chk("frame_err", frame_err_ff, 1'b1);
    chk("cmd_count", cmd_seen - c0, 8'h00);
    send(16'h0000, 0);
    chk("err_bit", resp[0], 1'b1);
    chk("frame_err", frame_err_ff, 1'b0);
  endtask
  task automatic s_ro;
    reset_output_pin <= 1'b0;
    @(posedge ref_clk);
    send(16'h5A84, 16);
    chk("sdo_high", resp, 16'hFFFF);
    chk("frame_err", frame_err_ff, 1'b1);
    reset_output_pin <= 1'b1;
    @(posedge ref_clk);
    send(16'h0000, 0);
    chk("err_bit", resp[0], 1'b1);
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    reset_output_pin = 1'b1;
    cur_mode = MODE_NORMAL;
    bus_ctrl_reg = 8'h01;
    wake_control_reg = 8'h01;
    wake_status_reg_a = 8'h00;
    wake_status_reg_b = 8'h00;
    mode_ctrl_reg = 8'h00;
    hw_ctrl_reg = 8'h00;
    read_data = 8'hC3;
    status_field = 7'h15;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("fail_reset", spi_fail_ff, 1'b0);
    chk("err_reset", frame_err_ff, 1'b0);
    s_write();
    s_modes();
    s_checks();
    s_stop_wake();
    s_extra();
    s_frame();
    s_ro();
    end_of_test();
  end
endmodule // tb_top
